// ===== core/irucfg_ask_if.sv
/*
 * carrier qualifier hookup: receive level in, qualified carrier out.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface irucfg_ask_if;
   logic rx_level;
   logic carrier_det;
   modport qual (input rx_level, output carrier_det);
   modport user (output rx_level, input carrier_det);
endinterface

// ===== core/irucfg_askq.sv
/*
 * ask receive qualifier: a high level counts as carrier only after it has
 * lasted the minimum on-time; detection drops after a long off gap.
 * assumes rx_level is already synchronised and polarity-corrected.
 */
`timescale 1ns/10ps
module irucfg_askq
   import irucfg_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rst,
   irucfg_ask_if.qual  ask
);
   irucfg_cnt_t on_q;
   irucfg_cnt_t off_q;
   logic        det_q;
   logic        qualified;

   assign qualified       = ask.rx_level && (on_q >= ASK_MIN_LEN - CNT_ONE);
   assign ask.carrier_det = det_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         on_q  <= CNT_ZERO;
         off_q <= CNT_ZERO;
         det_q <= 1'b0;
      end else begin
         on_q <= ask.rx_level ? ((on_q == ASK_MIN_LEN) ? on_q : on_q + CNT_ONE) : CNT_ZERO;
         // only a qualified pulse restarts the gap, so glitches cannot hold it
         if (qualified) begin
            det_q <= 1'b1;
            off_q <= CNT_ZERO;
         end else if (!ask.rx_level && det_q) begin
            off_q <= off_q + CNT_ONE;
            if (off_q >= ASK_OFF_LEN - CNT_ONE) begin
               det_q <= 1'b0;
            end
         end
      end
   end
endmodule

// ===== core/irucfg_clkdiv.sv
/*
 * uart reference tick: a fractional accumulator that gives ticks at the
 * 24 MHz rate, or at 24 MHz / 13, from the 50 MHz system clock.
 * assumes the uart core counts ticks rather than using them as a clock.
 */
`timescale 1ns/10ps
module irucfg_clkdiv
   import irucfg_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic fast_sel,
   output logic      tick
);
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_sum;
   logic [ACC_W-1:0] acc_mod;
   logic             wrap;

   assign acc_mod = fast_sel ? ACC_MOD_FAST : ACC_MOD_SLOW;
   assign acc_sum = acc_q + ACC_STEP;
   assign wrap    = acc_sum >= acc_mod;

   // a switch to the fast rate can leave acc beyond the modulus; restart it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= ACC_ZERO;
         tick  <= 1'b0;
      end else begin
         acc_q <= (acc_q >= acc_mod) ? ACC_ZERO : (wrap ? acc_sum - acc_mod : acc_sum);
         tick  <= wrap;
      end
   end
endmodule

// ===== core/irucfg_pkg.sv
/*
 * shared constants for the second-uart / infrared configuration block:
 * register offsets, field positions, reset values, keys, modes, timing.
 * assumes a 50 MHz system clock and an 8-bit register port.
 */
package irucfg_pkg;
   localparam int CLK_MHZ = 50;
   localparam int REF_MHZ = 24;
   localparam int UART_DIV = 13;

   typedef logic [7:0] irucfg_byte_t;

   localparam irucfg_byte_t ADDR_PIN_CFG = 8'h0C;
   localparam irucfg_byte_t ADDR_ROUTE   = 8'h0D;
   localparam irucfg_byte_t ADDR_KEY     = 8'h0F;

   localparam irucfg_byte_t CFG_RST   = 8'h00;
   localparam irucfg_byte_t ROUTE_RST = 8'h00;
   localparam irucfg_byte_t CFG_MASK  = 8'hEF;
   localparam irucfg_byte_t ZERO_BYTE = 8'h00;
   localparam irucfg_byte_t KEY_A     = 8'h88;
   localparam irucfg_byte_t KEY_B     = 8'h89;

   localparam int CFG_UA_FAST = 7;
   localparam int CFG_UB_FAST = 6;
   localparam int CFG_KEY_SEL = 5;
   localparam int CFG_ROLE    = 3;
   localparam int CFG_PIN_DEF = 2;
   localparam int CFG_RX_INV  = 1;
   localparam int CFG_TX_INV  = 0;

   localparam int RT_TX_HI  = 7;
   localparam int RT_TX_LO  = 6;
   localparam int RT_RX_HI  = 5;
   localparam int RT_RX_LO  = 4;
   localparam int RT_DUPLEX = 3;
   localparam int RT_MODE_HI = 2;
   localparam int RT_MODE_LO = 0;

   localparam logic [1:0] TXSEL_DEF  = 2'h0;
   localparam logic [1:0] TXSEL_A    = 2'h1;
   localparam logic [1:0] TXSEL_C    = 2'h2;
   localparam logic [1:0] TXSEL_DEF2 = 2'h3;
   localparam logic [1:0] RXSEL_DEF  = 2'h0;
   localparam logic [1:0] RXSEL_A    = 2'h1;
   localparam logic [1:0] RXSEL_B    = 2'h2;
   localparam logic [1:0] RXSEL_C    = 2'h3;

   typedef enum logic [2:0] {
      MODE_OFF0    = 3'b000,
      MODE_OFF1    = 3'b001,
      MODE_IRDA_FX = 3'b010,
      MODE_IRDA_BT = 3'b011,
      MODE_ASK_RAW = 3'b100,
      MODE_ASK_RC  = 3'b101,
      MODE_ASK_DEM = 3'b110,
      MODE_ASK_DC  = 3'b111
   } irucfg_mode_t;

   typedef enum logic {
      PST_IDLE  = 1'b0,
      PST_PULSE = 1'b1
   } irucfg_pst_t;

   localparam int ACC_W = 10;
   localparam logic [ACC_W-1:0] ACC_ZERO     = 10'h000;
   localparam logic [ACC_W-1:0] ACC_STEP     = ACC_W'(REF_MHZ);
   localparam logic [ACC_W-1:0] ACC_MOD_FAST = ACC_W'(CLK_MHZ);
   localparam logic [ACC_W-1:0] ACC_MOD_SLOW = ACC_W'(CLK_MHZ * UART_DIV);

   localparam int IRDA_PULSE_NS = 1600;
   localparam int ASK_MIN_NS    = 800;
   localparam int ASK_OFF_NS    = 1200;
   localparam int CARRIER_KHZ   = 500;
   localparam int IRDA_PULSE_CYC = (IRDA_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int ASK_MIN_CYC    = (ASK_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int ASK_OFF_CYC    = (ASK_OFF_NS * CLK_MHZ) / 1000;
   localparam int CARRIER_HALF_CYC = (CLK_MHZ * 1000) / (2 * CARRIER_KHZ);

   localparam int CNT_W = 8;
   typedef logic [CNT_W-1:0] irucfg_cnt_t;
   localparam irucfg_cnt_t CNT_ZERO    = 8'h00;
   localparam irucfg_cnt_t CNT_ONE     = 8'h01;
   localparam irucfg_cnt_t IRDA_LEN    = CNT_W'(IRDA_PULSE_CYC);
   localparam irucfg_cnt_t IRDA_BT_LEN = 8'h03;
   localparam irucfg_cnt_t ASK_MIN_LEN = CNT_W'(ASK_MIN_CYC);
   localparam irucfg_cnt_t ASK_OFF_LEN = CNT_W'(ASK_OFF_CYC);
   localparam irucfg_cnt_t CAR_HALF    = CNT_W'(CARRIER_HALF_CYC);
   localparam logic [3:0]  PHASE_LAST  = 4'hF;

   localparam int NPIN      = 8;
   localparam int PIN_RES   = 0;
   localparam int PIN_PCIN  = 1;
   localparam int PIN_SIN   = 2;
   localparam int PIN_KEY   = 3;
   localparam int PIN_DEF   = 4;
   localparam int PIN_ROLE  = 5;
   localparam int PIN_CS0   = 6;
   localparam int PIN_D7    = 7;
endpackage

// ===== core/irucfg_top.sv
/*
 * second-uart / infrared configuration block: two config registers and an
 * unlock key behind a plain register port, uart clock ticks, strap capture,
 * shared-pin routing and the ir transmit/receive shaping.
 * assumes rst is held for at least 3 clocks while straps are driven, and
 * that the uart, ide and gpio cores run on the same clock.
 */
// What this block does
// - bit 7 zero gives uart a 24 MHz divided by 13; one gives 24 MHz.
// - bit 6 selects the second uart's clock the same way.
// - bit 5 picks unlock key 88h when zero, 89h when one.
// - unlock-key select resets from its strap pin level.
// - bit 3 zero makes second uart infrared, one keeps plain serial.
// - uart/ir select resets from a pulled-up strap, serial when unstrapped.
// - bit 2 picks legacy ide pins or alternate ide plus gpio.
// - pin-definition select straps from its pin, then low or ide bus enable.
// - shared pin is high bus enable, or gpio line zero.
// - shared pin is ide data bit 7, or gpio line one.
// - bit 1 inverts second serial or infrared receive input.
// - bit 0 inverts second serial or infrared transmit output.
// - ask receive counts a carrier pulse only after 0.8 us high.
// - receive select 10 takes infrared input from the residence pin.
// - transmit select 00, the reset value, uses the parallel-direction pin.
// - receive select 00, the reset value, uses the parallel input pin.
// - routing can move infrared onto the second uart's serial pins.
// - routing can move infrared onto the two ide chip-select pins.
// - mode field: off, irda 1.6 us, irda 3/16 bit, or ask.
// - duplex bit zero is full duplex, one is half duplex.
`timescale 1ns/10ps
module irucfg_top
   import irucfg_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire irucfg_pkg::irucfg_byte_t addr,
   input  wire irucfg_pkg::irucfg_byte_t wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output irucfg_pkg::irucfg_byte_t rdata,
   output logic                     ext_func_enable,
   output logic                     uart_a_clk_tick,
   output logic                     uart_b_clk_tick,
   output logic                     second_uart_role_sel,
   output logic                     alt_pin_definition_sel,
   input  wire logic                second_serial_output,
   input  wire logic                uart_b_baud16_tick,
   output logic                     second_serial_input,
   input  wire logic                pin1_in,
   output logic                     drive_residence_input_n,
   input  wire logic                par_dir_in,
   output logic                     pin2_out,
   input  wire logic                pin3_in,
   output logic                     par_pin3_in,
   input  wire logic                pin41_in,
   input  wire logic                pin42_in,
   output logic                     pin43_out,
   input  wire logic                low_bus_buffer_enable_n,
   input  wire logic                ide_bus_buffer_enable_n,
   input  wire logic                pin91_in,
   output logic                     pin91_out,
   output logic                     pin91_oe,
   input  wire logic                high_bus_buffer_enable_n,
   input  wire logic                general_pin_zero_out,
   input  wire logic                general_pin_zero_oe,
   output logic                     general_pin_zero_in,
   input  wire logic                pin92_in,
   output logic                     pin92_out,
   output logic                     pin92_oe,
   input  wire logic                cs0_n,
   input  wire logic                pin94_in,
   output logic                     pin94_out,
   output logic                     pin94_oe,
   input  wire logic                cs1_n,
   output logic                     pin95_out,
   input  wire logic                ide_data_bit_seven_out,
   input  wire logic                ide_data_bit_seven_oe,
   output logic                     ide_data_bit_seven_in,
   input  wire logic                general_pin_one_out,
   input  wire logic                general_pin_one_oe,
   output logic                     general_pin_one_in,
   input  wire logic                pin96_in,
   output logic                     pin96_out,
   output logic                     pin96_oe
);
   irucfg_byte_t  cfg_q;
   irucfg_byte_t  route_q;
   logic          unlocked_q;
   logic          strap_pend_q;
   irucfg_byte_t  rdata_q;
   logic [NPIN-1:0] pin_s1_q;
   logic [NPIN-1:0] pin_s2_q;
   logic [NPIN-1:0] pin_raw;

   // pin synchronisers run through reset so the straps are settled at release
   assign pin_raw = {pin96_in, pin94_in, pin92_in, pin91_in, pin41_in,
                     pin42_in, pin3_in, pin1_in};
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            pin_s1_q[gi] <= pin_raw[gi];
            pin_s2_q[gi] <= pin_s1_q[gi];
         end
      end
   endgenerate

   // register port decode
   logic wr_cfg;
   logic wr_route;
   logic wr_key;
   logic [7:0] key_expect;
   irucfg_byte_t rd_mux;
   irucfg_byte_t status_word;
   irucfg_byte_t strap_cfg;

   assign wr_cfg     = wr && unlocked_q && (addr == ADDR_PIN_CFG);
   assign wr_route   = wr && unlocked_q && (addr == ADDR_ROUTE);
   assign wr_key     = wr && (addr == ADDR_KEY);
   assign key_expect = cfg_q[CFG_KEY_SEL] ? KEY_B : KEY_A;
   assign status_word = {7'h00, unlocked_q};
   assign rd_mux = (addr == ADDR_PIN_CFG) ? (cfg_q & CFG_MASK) :
                   (addr == ADDR_ROUTE)   ? route_q :
                   (addr == ADDR_KEY)     ? status_word : ZERO_BYTE;

   // strap-derived bits overlaid on the zero reset value
   always_comb begin
      strap_cfg = CFG_RST;
      strap_cfg[CFG_KEY_SEL] = pin_s2_q[PIN_KEY];
      strap_cfg[CFG_ROLE]    = pin_s2_q[PIN_ROLE];
      strap_cfg[CFG_PIN_DEF] = pin_s2_q[PIN_DEF];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q        <= CFG_RST;
         route_q      <= ROUTE_RST;
         unlocked_q   <= 1'b0;
         strap_pend_q <= 1'b1;
         rdata_q      <= ZERO_BYTE;
      end else begin
         strap_pend_q <= 1'b0;
         if (strap_pend_q) begin
            cfg_q <= strap_cfg;
         end else if (wr_cfg) begin
            cfg_q <= wdata & CFG_MASK;
         end
         if (wr_route) begin
            route_q <= wdata;
         end
         // any other value written to the key register locks again
         if (wr_key) begin
            unlocked_q <= (wdata == key_expect);
         end
         rdata_q <= rd ? rd_mux : ZERO_BYTE;
      end
   end

   assign rdata           = rdata_q;
   assign ext_func_enable = unlocked_q;

   // uart reference ticks
   irucfg_clkdiv u_div_a (
      .clk      (clk),
      .rst      (rst),
      .fast_sel (cfg_q[CFG_UA_FAST]),
      .tick     (uart_a_clk_tick)
   );
   irucfg_clkdiv u_div_b (
      .clk      (clk),
      .rst      (rst),
      .fast_sel (cfg_q[CFG_UB_FAST]),
      .tick     (uart_b_clk_tick)
   );

   // field views
   logic        ir_sel;
   logic        pin_def;
   logic        rx_inv;
   logic        tx_inv;
   logic [1:0]  tx_sel;
   logic [1:0]  rx_sel;
   logic        half_dup;
   irucfg_mode_t mode;

   assign ir_sel   = !cfg_q[CFG_ROLE];
   assign pin_def  = cfg_q[CFG_PIN_DEF];
   assign rx_inv   = cfg_q[CFG_RX_INV];
   assign tx_inv   = cfg_q[CFG_TX_INV];
   assign tx_sel   = route_q[RT_TX_HI:RT_TX_LO];
   assign rx_sel   = route_q[RT_RX_HI:RT_RX_LO];
   assign half_dup = route_q[RT_DUPLEX];
   assign mode     = irucfg_mode_t'(route_q[RT_MODE_HI:RT_MODE_LO]);

   // irda pulse shaping: one pulse at the start of every zero bit
   irucfg_pst_t pst_q;
   irucfg_cnt_t pcnt_q;
   logic [3:0]  phase_q;
   logic        sout_prev_q;
   logic        sout_fall;
   logic        bit_start;
   logic        bt_mode;
   irucfg_cnt_t pulse_len;
   logic        pulse_step;

   assign sout_fall  = sout_prev_q && !second_serial_output;
   assign bit_start  = sout_fall ||
                       (uart_b_baud16_tick && phase_q == PHASE_LAST && !second_serial_output);
   assign bt_mode    = (mode == MODE_IRDA_BT);
   assign pulse_len  = bt_mode ? IRDA_BT_LEN : IRDA_LEN;
   assign pulse_step = bt_mode ? uart_b_baud16_tick : 1'b1;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sout_prev_q <= 1'b1;
         phase_q     <= 4'h0;
      end else begin
         sout_prev_q <= second_serial_output;
         // falling edge re-aligns the bit phase to the start bit
         phase_q <= sout_fall ? 4'h0 : (uart_b_baud16_tick ? phase_q + 4'h1 : phase_q);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pst_q  <= PST_IDLE;
         pcnt_q <= CNT_ZERO;
      end else begin
         case (pst_q)
            PST_IDLE: begin
               if (bit_start) begin
                  pst_q  <= PST_PULSE;
                  pcnt_q <= CNT_ZERO;
               end
            end
            PST_PULSE: begin
               if (pulse_step) begin
                  pcnt_q <= pcnt_q + CNT_ONE;
                  if (pcnt_q == pulse_len - CNT_ONE) begin
                     pst_q <= PST_IDLE;
                  end
               end
            end
            default: begin
               pst_q <= PST_IDLE;
            end
         endcase
      end
   end

   // ask carrier
   irucfg_cnt_t car_cnt_q;
   logic        car_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         car_cnt_q <= CNT_ZERO;
         car_q     <= 1'b0;
      end else if (car_cnt_q == CAR_HALF - CNT_ONE) begin
         car_cnt_q <= CNT_ZERO;
         car_q     <= !car_q;
      end else begin
         car_cnt_q <= car_cnt_q + CNT_ONE;
      end
   end

   // transmit level before polarity
   logic ir_tx;
   logic tx_busy;
   always_comb begin
      case (mode)
         MODE_IRDA_FX, MODE_IRDA_BT: ir_tx = (pst_q == PST_PULSE);
         MODE_ASK_RAW, MODE_ASK_DEM: ir_tx = !second_serial_output;
         MODE_ASK_RC, MODE_ASK_DC:   ir_tx = !second_serial_output && car_q;
         default:                    ir_tx = 1'b1;
      endcase
   end
   assign tx_busy = !second_serial_output || (pst_q == PST_PULSE);

   // receive pin choice and polarity
   logic ir_rx_pin;
   logic ir_rx;
   logic sin_d;
   irucfg_ask_if ask_bus ();

   assign ir_rx_pin = (rx_sel == RXSEL_A) ? pin_s2_q[PIN_SIN] :
                      (rx_sel == RXSEL_B) ? pin_s2_q[PIN_RES] :
                      (rx_sel == RXSEL_C) ? pin_s2_q[PIN_CS0] :
                      pin_s2_q[PIN_PCIN];
   assign ir_rx = ir_rx_pin ^ rx_inv;
   assign ask_bus.rx_level = ir_rx;

   irucfg_askq u_askq (
      .clk (clk),
      .rst (rst),
      .ask (ask_bus)
   );

   always_comb begin
      if (!ir_sel) begin
         sin_d = pin_s2_q[PIN_SIN] ^ rx_inv;
      end else if (half_dup && tx_busy) begin
         sin_d = 1'b1;
      end else begin
         case (mode)
            MODE_IRDA_FX, MODE_IRDA_BT: sin_d = !ir_rx;
            MODE_ASK_RAW, MODE_ASK_RC:  sin_d = ir_rx;
            MODE_ASK_DEM, MODE_ASK_DC:  sin_d = !ask_bus.carrier_det;
            default:                    sin_d = 1'b1;
         endcase
      end
   end

   // transmit pin routing, applied only with the infrared role
   logic tx_pin_lvl;
   logic use_tx_def;
   logic use_tx_a;
   logic use_tx_c;
   logic use_rx_c;

   assign tx_pin_lvl = ir_tx ^ tx_inv;
   assign use_tx_def = ir_sel && (tx_sel == TXSEL_DEF || tx_sel == TXSEL_DEF2);
   assign use_tx_a   = ir_sel && (tx_sel == TXSEL_A);
   assign use_tx_c   = ir_sel && (tx_sel == TXSEL_C);
   assign use_rx_c   = ir_sel && (rx_sel == RXSEL_C);

   // pin outputs are registered; enables stay off until the straps are in
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         second_serial_input <= 1'b1;
         pin2_out  <= 1'b0;
         pin43_out <= 1'b1;
         pin95_out <= 1'b1;
         pin94_out <= 1'b1;
         pin94_oe  <= 1'b0;
         pin91_out <= 1'b1;
         pin91_oe  <= 1'b0;
         pin92_out <= 1'b1;
         pin92_oe  <= 1'b0;
         pin96_out <= 1'b0;
         pin96_oe  <= 1'b0;
      end else begin
         second_serial_input <= sin_d;
         pin2_out  <= use_tx_def ? tx_pin_lvl : par_dir_in;
         pin43_out <= use_tx_a ? tx_pin_lvl : (second_serial_output ^ tx_inv);
         pin95_out <= use_tx_c ? tx_pin_lvl : cs1_n;
         pin94_out <= cs0_n;
         pin94_oe  <= !use_rx_c && !strap_pend_q;
         pin91_out <= pin_def ? ide_bus_buffer_enable_n : low_bus_buffer_enable_n;
         pin91_oe  <= !strap_pend_q;
         pin92_out <= pin_def ? general_pin_zero_out : high_bus_buffer_enable_n;
         pin92_oe  <= !strap_pend_q && (pin_def ? general_pin_zero_oe : 1'b1);
         pin96_out <= pin_def ? general_pin_one_out : ide_data_bit_seven_out;
         pin96_oe  <= !strap_pend_q &&
                      (pin_def ? general_pin_one_oe : ide_data_bit_seven_oe);
      end
   end

   assign drive_residence_input_n = pin_s2_q[PIN_RES];
   assign par_pin3_in             = pin_s2_q[PIN_PCIN];
   assign general_pin_zero_in     = pin_s2_q[PIN_ROLE];
   assign ide_data_bit_seven_in   = pin_s2_q[PIN_D7];
   assign general_pin_one_in      = pin_s2_q[PIN_D7];
   assign second_uart_role_sel    = cfg_q[CFG_ROLE];
   assign alt_pin_definition_sel  = pin_def;
endmodule

// ===== verif/irucfg_top_assertions.sv
/* port assertions for the second-uart / infrared configuration block.
   assumes it is bound into irucfg_top and sees its ports only. */
`timescale 1ns/10ps
module irucfg_top_assertions
   import irucfg_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     rst,
   input wire irucfg_pkg::irucfg_byte_t addr,
   input wire irucfg_pkg::irucfg_byte_t wdata,
   input wire logic                     wr,
   input wire logic                     rd,
   input wire irucfg_pkg::irucfg_byte_t rdata,
   input wire logic                     ext_func_enable,
   input wire logic                     uart_a_clk_tick,
   input wire logic                     second_uart_role_sel,
   input wire logic                     alt_pin_definition_sel,
   input wire logic                     pin91_out,
   input wire logic                     low_bus_buffer_enable_n,
   input wire logic                     ide_bus_buffer_enable_n
);
   logic [1:0] up_q;
   logic       fa_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence cfg_wr;
      wr && addr == ADDR_PIN_CFG && ext_func_enable;
   endsequence
   // mirror of the uart a speed bit; it leads the ticks, so the gap check errs safe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         up_q <= 2'h0;
         fa_q <= 1'b0;
      end else begin
         up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
         fa_q <= (wr && addr == ADDR_PIN_CFG && ext_func_enable) ? wdata[CFG_UA_FAST] : fa_q;
      end
   end
   chk_role_write: assert property (
      cfg_wr |=> second_uart_role_sel == $past(wdata[CFG_ROLE])) else $error("role bit missed");
   chk_pindef_write: assert property (
      cfg_wr |=> alt_pin_definition_sel == $past(wdata[CFG_PIN_DEF])) else $error("pin bit missed");
   chk_lock_hold: assert property (
      wr && addr == ADDR_PIN_CFG && !ext_func_enable |=> $stable(second_uart_role_sel)
      && $stable(alt_pin_definition_sel)) else $error("locked write took effect");
   chk_key_wrong: assert property (
      wr && addr == ADDR_KEY && wdata != KEY_A && wdata != KEY_B |=> !ext_func_enable)
      else $error("wrong key left unlocked");
   chk_key_read: assert property (
      rd && addr == ADDR_KEY |=> rdata == {7'h00, $past(ext_func_enable)})
      else $error("key status read wrong");
   chk_cfg_read: assert property (
      rd && addr == ADDR_PIN_CFG |=> !rdata[4] && rdata[CFG_ROLE] == $past(second_uart_role_sel))
      else $error("config read wrong");
   chk_pin_mux: assert property (
      up_q == 2'h3 |-> pin91_out == $past(alt_pin_definition_sel ? ide_bus_buffer_enable_n
      : low_bus_buffer_enable_n)) else $error("shared enable pin wrong");
   chk_slow_gap: assert property (
      uart_a_clk_tick && !fa_q |=> (!uart_a_clk_tick || fa_q) [*8]) else $error("slow tick early");
endmodule
bind irucfg_top irucfg_top_assertions u_chk (.*);

// ===== verif/irucfg_top_tb.sv
/* self-checking bench for irucfg_top: straps, key lock, ticks, pin muxing,
   polarity and infrared shaping. assumes the package and core are compiled first. */
`timescale 1ns/10ps
module irucfg_top_tb;
   import irucfg_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, second_serial_output = 1, uart_b_baud16_tick = 0;
   logic pin1_in = 1, par_dir_in = 1, pin3_in = 0, pin41_in = 1, pin42_in = 1, pin91_in = 0;
   logic pin92_in = 1, low_bus_buffer_enable_n = 0, ide_bus_buffer_enable_n = 1, cs0_n = 1;
   logic high_bus_buffer_enable_n = 0, general_pin_zero_out = 1, general_pin_zero_oe = 0;
   logic cs1_n = 1, pin94_in = 1, pin96_in = 0, ide_data_bit_seven_out = 0;
   logic ide_data_bit_seven_oe = 0, general_pin_one_out = 1, general_pin_one_oe = 0;
   irucfg_byte_t addr = 8'h00, wdata = 8'h00, rdata;
   logic ext_func_enable, uart_a_clk_tick, uart_b_clk_tick, second_uart_role_sel, tx;
   logic alt_pin_definition_sel, second_serial_input, drive_residence_input_n, pin2_out;
   logic par_pin3_in, pin43_out, pin91_out, pin91_oe, general_pin_zero_in, pin92_out, pin92_oe;
   logic pin94_out, pin94_oe, pin95_out, ide_data_bit_seven_in, general_pin_one_in;
   logic pin96_out, pin96_oe;
   int n_errors = 0, total_checks = 0, na, nb, f, s;
   irucfg_byte_t rt [7] = '{8'h00, 8'h04, 8'h24, 8'h54, 8'h84, 8'hF4, 8'h02};
   logic [1:0] ex [7] = '{2'h3, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2, 2'h2};
   irucfg_top u_irucfg_top (.*);
   always #10 clk = ~clk;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr8(input irucfg_byte_t a, input irucfg_byte_t d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input irucfg_byte_t a, input irucfg_byte_t e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic results;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      n_errors++;
      results();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wr8(ADDR_PIN_CFG, 8'h00);
      rd8(ADDR_PIN_CFG, 8'h28);
      rd8(ADDR_ROUTE, ROUTE_RST);
      wr8(ADDR_KEY, KEY_A);
      rd8(ADDR_KEY, 8'h00);
      wr8(ADDR_KEY, KEY_B);
      rd8(ADDR_KEY, 8'h01);
      wr8(ADDR_PIN_CFG, 8'hFF);
      rd8(ADDR_PIN_CFG, CFG_MASK);
      wr8(ADDR_KEY, 8'h55);
      rd8(ADDR_KEY, 8'h00);
      wr8(ADDR_KEY, KEY_A);
      rd8(ADDR_KEY, 8'h00);
      wr8(ADDR_KEY, KEY_B);
      rd8(ADDR_KEY, 8'h01);
      rd8(8'h40, ZERO_BYTE);
      for (int i = 0; i < 2; i++) begin
         wr8(ADDR_PIN_CFG, i ? 8'h48 : 8'h88);
         settle(4);
         na = 0;
         nb = 0;
         repeat (650) begin
            @(posedge clk);
            #1;
            na += uart_a_clk_tick;
            nb += uart_b_clk_tick;
         end
         f = i ? nb : na;
         s = i ? na : nb;
         chk((f > 310 && f < 314) ? 16'h0138 : 16'(f), 16'h0138);
         chk((s > 22 && s < 26) ? 16'h0018 : 16'(s), 16'h0018);
      end
      for (int j = 0; j < 2; j++) begin
         wr8(ADDR_PIN_CFG, j ? 8'h0C : 8'h08);
         {general_pin_zero_oe, general_pin_one_oe, ide_data_bit_seven_oe, cs1_n} <= {4{j[0]}};
         settle(4);
         chk({pin91_out, pin92_out, pin96_out}, {3{j[0]}});
         chk({pin91_oe, pin92_oe, pin96_oe}, {2'h3, j[0]});
      end
      for (int k = 0; k < 4; k++) begin
         wr8(ADDR_PIN_CFG, 8'h08 | 8'(k));
         pin42_in <= 1'b0;
         settle(5);
         chk({second_serial_input, pin43_out}, {k[1], ~k[0]});
      end
      wr8(ADDR_PIN_CFG, 8'h00);
      for (int m = 0; m < 7; m++) begin
         wr8(ADDR_ROUTE, rt[m]);
         settle(5);
         tx = rt[m][7:6] == 2'h1 ? pin43_out : rt[m][7:6] == 2'h2 ? pin95_out : pin2_out;
         chk({second_serial_input, tx}, ex[m]);
         chk(pin94_oe, rt[m][5:4] != 2'h3);
      end
      chk({drive_residence_input_n, par_pin3_in, general_pin_zero_in, ide_data_bit_seven_in,
           general_pin_one_in, pin94_out}, 6'h29);
      // one falling edge of the serial output must give exactly one fixed-width pulse
      @(posedge clk) second_serial_output <= 1'b0;
      na = 0;
      repeat (300) begin
         @(posedge clk);
         #1;
         na += pin2_out;
      end
      chk(16'(na), 16'h0050);
      @(posedge clk) second_serial_output <= 1'b1;
      wr8(ADDR_ROUTE, 8'h06);
      pin3_in <= 1'b1;
      repeat (30) @(posedge clk);
      pin3_in <= 1'b0;
      settle(5);
      chk(second_serial_input, 1'b1);
      @(posedge clk) pin3_in <= 1'b1;
      settle(50);
      chk(second_serial_input, 1'b0);
      // with the receive pin high, full duplex would give 0 here
      wr8(ADDR_ROUTE, 8'h0A);
      second_serial_output <= 1'b0;
      settle(5);
      chk(second_serial_input, 1'b1);
      // carrier mode: any 100-cycle window holds exactly one carrier period
      wr8(ADDR_ROUTE, 8'h05);
      na = 0;
      repeat (100) begin
         @(posedge clk);
         #1;
         na += pin2_out;
      end
      chk(16'(na), 16'h0032);
      results();
   end
endmodule
